// ==== rmmd_pkg.sv ====
// Purpose: Shared constants and types for the rate match, multiplex and DTX datapath
// Assumes: 32-bit AXI4-Lite register words, one aligned word per register
// Notes:   Register index times four gives the byte address
package rmmd_pkg;
    // Register indices (byte address is index times four)
    localparam logic [3:0] REG_CTRL      = 4'h0;
    localparam logic [3:0] REG_CMD       = 4'h1;
    localparam logic [3:0] REG_NBITS     = 4'h2;
    localparam logic [3:0] REG_PAD       = 4'h3;
    localparam logic [3:0] REG_EINI_A    = 4'h4;
    localparam logic [3:0] REG_EPLUS_A   = 4'h5;
    localparam logic [3:0] REG_EMINUS_A  = 4'h6;
    localparam logic [3:0] REG_EINI_B    = 4'h7;
    localparam logic [3:0] REG_EPLUS_B   = 4'h8;
    localparam logic [3:0] REG_EMINUS_B  = 4'h9;
    localparam logic [3:0] REG_STATUS    = 4'ha;
    localparam logic [3:0] REG_CHAN_CNT  = 4'hb;
    localparam logic [3:0] REG_FRAME_CNT = 4'hc;
    localparam int         NUM_REGS      = 13;
    localparam int         NUM_CFG       = 10;
    // Control register fields
    localparam int CTRL_DL     = 0;
    localparam int CTRL_TURBO  = 1;
    localparam int CTRL_FLEX   = 2;
    localparam int CTRL_PUNCT  = 3;
    localparam int CTRL_BYPASS = 4;
    localparam int CTRL_TTI    = 5;
    localparam int CTRL_FIDX   = 7;
    // Command register fields
    localparam int CMD_GO      = 0;
    localparam int CMD_FLUSH   = 1;
    localparam int CMD_NEWFRM  = 2;
    localparam int CMD_W       = 3;
    // Interval codes
    localparam logic [1:0] TTI_10 = 2'h0;
    localparam logic [1:0] TTI_20 = 2'h1;
    localparam logic [1:0] TTI_40 = 2'h2;
    localparam logic [1:0] TTI_80 = 2'h3;
    // Bit types: systematic, first parity, second parity
    localparam logic [1:0] BT_X  = 2'h0;
    localparam logic [1:0] BT_Y  = 2'h1;
    localparam logic [1:0] BT_YP = 2'h2;
    // Reset values and bus answers
    localparam logic [31:0] CFG_RST     = 32'h0;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // Datapath states
    typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_REP, ST_PAD, ST_FLUSH} rmmd_state_e;
endpackage

// ==== rmmd_src.sv ====
// Purpose: Upstream bit source standing in for the segmentation stage
// Assumes: Pattern and count are set while the source is restarted
// Notes:   Released data line shows the inverse of the last bit sent
`timescale 1ns/100ps
module rmmd_src (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Job setup
    input  wire logic        restart,
    input  wire logic [31:0] pattern,
    input  wire logic [7:0]  nbits,
    // Bit stream towards the block
    output logic             in_valid,
    input  wire logic        in_ready,
    output logic             in_bit
);
    logic [7:0] idx_q;  // Next bit to offer
    logic [7:0] idx_d;

    // Advance only on an accepted bit, so each bit stands until taken
    always_comb begin
        idx_d = idx_q;
        if (restart) begin
            idx_d = 8'h0;
        end else if (in_valid && in_ready) begin
            idx_d = idx_q + 8'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idx_q <= 8'h0;
        end else begin
            idx_q <= idx_d;
        end
    end

    // Valid holds until every bit of the job is gone
    assign in_valid = (idx_q < nbits);
    // Idle line must not keep the last bit, or a stray sample would look right
    assign in_bit   = in_valid ? pattern[idx_q[4:0]] : ~pattern[idx_q[4:0] - 5'h1];
endmodule

// ==== rmmd_top.sv ====
// Purpose: Bit separation, rate matching, serial multiplexing and DTX insertion
// Assumes: Software sets parameters per channel job; one job per channel, in order
// Notes:   Output symbols carry a data bit and a DTX flag
// Notes on behaviour
// [RULE1] Uplink turbo: parity streams punctured, systematic never
// [RULE2] Uplink cycle order chosen by interval
// [RULE3] Start type follows frame index table
// [RULE4] Classify bits by stepping the cycle
// [RULE5] Downlink separation order fixed from first bit
// [RULE6] Downlink turbo: parity punctured, systematic kept
// [RULE7] Puncture: subtract minus, drop and add plus
// [RULE8] Repeat: copy while accumulator not positive
// [RULE9] Copies follow original before next input
// [RULE10] Uplink frame output is N plus adjustment
// [RULE11] Downlink interval output is N plus adjustment
// [RULE12] One frame per channel per period, serially
// [RULE13] Channels back to back, no gaps
// [RULE14] Downlink fills spare capacity with DTX symbols
// [RULE15] Fixed positions pad each channel to reserve
// [RULE16] Flexible positions pad frame end to total
// [RULE17] Network side keeps position choice per connection
// [RULE18] Zero adjustment bypasses rate matching
// [RULE19] Symbol is data bit plus DTX flag
// [RULE20] Valid/ready streams; stall input while repeating
`timescale 1ns/100ps
module rmmd_top #(
    parameter int EW = 24,  // Accumulator width
    parameter int CW = 20,  // Bit counter width
    parameter int AW = 8    // Bus address width
) (
    // Clock, reset, enable
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          ce,
    // AXI4-Lite write channels
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic [2:0]    s_axi_awprot,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic [2:0]    s_axi_arprot,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    // Input bit stream
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic          in_bit,
    // Output symbol stream
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic               out_bit,
    output logic               out_dtx
);
    // Bus state
    logic        awready_q, awready_d, bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] cfg_q [rmmd_pkg::NUM_CFG];  // Writable configuration words
    logic [31:0] cfg_d [rmmd_pkg::NUM_CFG];
    logic [rmmd_pkg::CMD_W-1:0] cmd_q, cmd_d;  // One-cycle command pulses
    logic [4:0]  wdec, rdec;
    // Datapath state
    rmmd_pkg::rmmd_state_e st_q, st_d;
    logic [CW-1:0]   in_cnt_q, in_cnt_d, chan_cnt_q, chan_cnt_d, frame_cnt_q, frame_cnt_d;
    logic [1:0]      type_q, type_d;
    logic signed [EW-1:0] ea_q, ea_d, eb_q, eb_d;
    logic            hold_q, hold_d, ready_q, ready_d;
    logic            ov_q, ov_d, ob_q, ob_d, od_q, od_d;
    // Decoded controls and per-bit terms
    logic            dl, turbo, flex, punct, bypass, alt_rev, acc, load, is_x, use_b;
    logic [1:0]      transmission_interval;
    logic [2:0]      fidx;
    logic [CW-1:0]   nbits, pad;
    logic signed [EW-1:0] em, ep, e1, e2;

    // Address decode: bit 4 flags a mapped word, low bits give its index
    function automatic logic [4:0] reg_dec(input logic [AW-1:0] a);
        logic ok;
        ok = (a[1:0] == 2'h0) && (a[AW-1:2] < (AW-2)'(rmmd_pkg::NUM_REGS));
        return {ok, a[5:2]};
    endfunction

    // Starting bit type of a frame
    function automatic logic [1:0] start_type(input logic d, input logic [1:0] t, input logic [2:0] i);
        logic [1:0] r;
        r = rmmd_pkg::BT_X;
        if (!d) begin
            case (t)
                rmmd_pkg::TTI_20: r = i[0] ? rmmd_pkg::BT_Y : rmmd_pkg::BT_X;
                rmmd_pkg::TTI_40: begin
                    case (i[1:0])
                        2'h1:    r = rmmd_pkg::BT_YP;
                        2'h2:    r = rmmd_pkg::BT_Y;
                        default: r = rmmd_pkg::BT_X;
                    endcase
                end
                rmmd_pkg::TTI_80: begin
                    case (i)
                        3'h1, 3'h4, 3'h7: r = rmmd_pkg::BT_Y;
                        3'h2, 3'h5:       r = rmmd_pkg::BT_YP;
                        default:          r = rmmd_pkg::BT_X;
                    endcase
                end
                default: r = rmmd_pkg::BT_X;
            endcase
        end
        return r;
    endfunction

    // Next bit type in the alternation cycle
    function automatic logic [1:0] next_type(input logic [1:0] t, input logic rev);
        logic [1:0] r;
        case (t)
            rmmd_pkg::BT_X: r = rev ? rmmd_pkg::BT_YP : rmmd_pkg::BT_Y;
            rmmd_pkg::BT_Y: r = rev ? rmmd_pkg::BT_X : rmmd_pkg::BT_YP;
            default:        r = rev ? rmmd_pkg::BT_Y : rmmd_pkg::BT_X;
        endcase
        return r;
    endfunction

    // Bus slave next state; write and read run independently, one of each at a time
    always_comb begin
        awready_d = 1'b0;
        arready_d = 1'b0;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        cfg_d     = cfg_q;
        cmd_d     = '0;
        wdec      = reg_dec(s_axi_awaddr);
        rdec      = reg_dec(s_axi_araddr);
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        // Both address and data present: take them on one edge
        if (s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q) begin
            awready_d = 1'b1;
            bvalid_d  = 1'b1;
            bresp_d   = wdec[4] ? rmmd_pkg::RESP_OKAY : rmmd_pkg::RESP_SLVERR;
            if (wdec[4] && wdec[3:0] == rmmd_pkg::REG_CMD) begin
                cmd_d = s_axi_wstrb[0] ? s_axi_wdata[rmmd_pkg::CMD_W-1:0] : '0;
            end else if (wdec[4] && wdec[3:0] < 4'(rmmd_pkg::NUM_CFG)) begin
                for (int b = 0; b < 4; b++) begin
                    if (s_axi_wstrb[b]) begin
                        cfg_d[wdec[3:0]][8*b +: 8] = s_axi_wdata[8*b +: 8];
                    end
                end
            end
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        // Read answer raised on the same edge that takes the address
        if (s_axi_arvalid && !arready_q && !rvalid_q) begin
            arready_d = 1'b1;
            rvalid_d  = 1'b1;
            rresp_d   = rdec[4] ? rmmd_pkg::RESP_OKAY : rmmd_pkg::RESP_SLVERR;
            case (rdec[3:0])
                rmmd_pkg::REG_CMD:       rdata_d = 32'h0;
                rmmd_pkg::REG_STATUS:    rdata_d = {29'h0, st_q == rmmd_pkg::ST_REP, ov_q, st_q != rmmd_pkg::ST_IDLE};
                rmmd_pkg::REG_CHAN_CNT:  rdata_d = {{(32-CW){1'b0}}, chan_cnt_q};
                rmmd_pkg::REG_FRAME_CNT: rdata_d = {{(32-CW){1'b0}}, frame_cnt_q};
                default:                 rdata_d = (rdec[4] && rdec[3:0] < 4'(rmmd_pkg::NUM_CFG)) ? cfg_q[rdec[3:0]] : 32'h0;
            endcase
        end
    end

    // Bus registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            arready_q <= 1'b0;
            bvalid_q  <= 1'b0;
            rvalid_q  <= 1'b0;
            bresp_q   <= rmmd_pkg::RESP_OKAY;
            rresp_q   <= rmmd_pkg::RESP_OKAY;
            rdata_q   <= 32'h0;
            cmd_q     <= '0;
            for (int k = 0; k < rmmd_pkg::NUM_CFG; k++) begin
                cfg_q[k] <= rmmd_pkg::CFG_RST;
            end
        end else if (ce) begin
            awready_q <= awready_d;
            arready_q <= arready_d;
            bvalid_q  <= bvalid_d;
            rvalid_q  <= rvalid_d;
            bresp_q   <= bresp_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
            cmd_q     <= cmd_d;
            cfg_q     <= cfg_d;
        end
    end

    // Datapath next state
    always_comb begin
        dl      = cfg_q[rmmd_pkg::REG_CTRL][rmmd_pkg::CTRL_DL];
        turbo   = cfg_q[rmmd_pkg::REG_CTRL][rmmd_pkg::CTRL_TURBO];
        flex    = cfg_q[rmmd_pkg::REG_CTRL][rmmd_pkg::CTRL_FLEX];
        punct   = cfg_q[rmmd_pkg::REG_CTRL][rmmd_pkg::CTRL_PUNCT];
        bypass  = cfg_q[rmmd_pkg::REG_CTRL][rmmd_pkg::CTRL_BYPASS];
        transmission_interval     = cfg_q[rmmd_pkg::REG_CTRL][rmmd_pkg::CTRL_TTI +: 2];
        fidx    = cfg_q[rmmd_pkg::REG_CTRL][rmmd_pkg::CTRL_FIDX +: 3];
        nbits   = cfg_q[rmmd_pkg::REG_NBITS][CW-1:0];
        pad     = cfg_q[rmmd_pkg::REG_PAD][CW-1:0];
        alt_rev = !dl && (transmission_interval == rmmd_pkg::TTI_20 || transmission_interval == rmmd_pkg::TTI_80);  // RULE2 RULE5
        // Only turbo puncturing splits streams; repetition uses the common set
        is_x    = turbo && punct && type_q == rmmd_pkg::BT_X;   // RULE1 RULE6
        use_b   = turbo && punct && type_q == rmmd_pkg::BT_YP;  // RULE1 RULE6
        em      = $signed(use_b ? cfg_q[rmmd_pkg::REG_EMINUS_B][EW-1:0] : cfg_q[rmmd_pkg::REG_EMINUS_A][EW-1:0]);
        ep      = $signed(use_b ? cfg_q[rmmd_pkg::REG_EPLUS_B][EW-1:0] : cfg_q[rmmd_pkg::REG_EPLUS_A][EW-1:0]);
        e1      = (use_b ? eb_q : ea_q) - em;
        e2      = e1 + ep;
        acc     = in_valid && ready_q;  // RULE20
        load    = 1'b0;
        st_d    = st_q;
        in_cnt_d    = in_cnt_q;
        chan_cnt_d  = chan_cnt_q;
        frame_cnt_d = frame_cnt_q;
        type_d  = type_q;
        ea_d    = ea_q;
        eb_d    = eb_q;
        hold_d  = hold_q;
        ov_d    = (ov_q && out_ready) ? 1'b0 : ov_q;
        ob_d    = ob_q;
        od_d    = od_q;
        case (st_q)
            rmmd_pkg::ST_IDLE: begin
                if (cmd_q[rmmd_pkg::CMD_NEWFRM]) begin
                    frame_cnt_d = '0;  // RULE12
                end
                if (cmd_q[rmmd_pkg::CMD_GO]) begin
                    st_d       = rmmd_pkg::ST_RUN;
                    in_cnt_d   = '0;
                    chan_cnt_d = '0;
                    ea_d       = $signed(cfg_q[rmmd_pkg::REG_EINI_A][EW-1:0]);  // RULE7
                    eb_d       = $signed(cfg_q[rmmd_pkg::REG_EINI_B][EW-1:0]);
                    type_d     = start_type(dl, transmission_interval, fidx);  // RULE3 RULE5
                end else if (cmd_q[rmmd_pkg::CMD_FLUSH] && flex) begin
                    st_d = rmmd_pkg::ST_FLUSH;  // RULE16
                end
            end
            rmmd_pkg::ST_RUN: begin
                if (acc) begin
                    in_cnt_d = in_cnt_q + 1'b1;  // RULE10 RULE11
                    type_d   = next_type(type_q, alt_rev);  // RULE4
                    hold_d   = in_bit;
                    if (bypass || is_x) begin
                        load = 1'b1;  // RULE18 RULE1 RULE6
                    end else if (punct) begin
                        load = (e1 > 0);  // RULE7
                        if (use_b) begin
                            eb_d = (e1 > 0) ? e1 : e2;
                        end else begin
                            ea_d = (e1 > 0) ? e1 : e2;
                        end
                    end else begin
                        load = 1'b1;  // RULE8
                        ea_d = e1;
                        if (e1 <= 0) begin
                            st_d = rmmd_pkg::ST_REP;  // RULE9
                        end
                    end
                end else if (in_cnt_q == nbits) begin
                    // Fixed positions pad each channel; flexible waits for frame flush
                    st_d = (!flex && chan_cnt_q < pad) ? rmmd_pkg::ST_PAD : rmmd_pkg::ST_IDLE;  // RULE15
                end
            end
            rmmd_pkg::ST_REP: begin
                // Copy follows the original before any new input is taken
                if (!ov_q || out_ready) begin
                    load = 1'b1;  // RULE9
                    ea_d = ea_q + $signed(cfg_q[rmmd_pkg::REG_EPLUS_A][EW-1:0]);  // RULE8
                    if (ea_d > 0) begin
                        st_d = rmmd_pkg::ST_RUN;
                    end
                end
            end
            rmmd_pkg::ST_PAD: begin
                if (chan_cnt_q >= pad) begin
                    st_d = rmmd_pkg::ST_IDLE;
                end else if (!ov_q || out_ready) begin
                    load = 1'b1;  // RULE15 RULE14
                end
            end
            rmmd_pkg::ST_FLUSH: begin
                if (frame_cnt_q >= pad) begin
                    st_d = rmmd_pkg::ST_IDLE;
                end else if (!ov_q || out_ready) begin
                    load = 1'b1;  // RULE16 RULE14
                end
            end
            default: st_d = rmmd_pkg::ST_IDLE;
        endcase
        if (load) begin
            ov_d        = 1'b1;  // RULE13
            od_d        = (st_q == rmmd_pkg::ST_PAD || st_q == rmmd_pkg::ST_FLUSH);  // RULE19
            ob_d        = od_d ? 1'b0 : (st_q == rmmd_pkg::ST_REP ? hold_q : in_bit);
            chan_cnt_d  = chan_cnt_q + 1'b1;
            frame_cnt_d = frame_cnt_q + 1'b1;
        end
        // Take input only into an empty output slot; halves peak rate but needs no skid buffer
        ready_d = (st_d == rmmd_pkg::ST_RUN) && (in_cnt_d != nbits) && !ov_d;  // RULE20
    end

    // Datapath registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q        <= rmmd_pkg::ST_IDLE;
            in_cnt_q    <= '0;
            chan_cnt_q  <= '0;
            frame_cnt_q <= '0;
            type_q      <= rmmd_pkg::BT_X;
            ea_q        <= '0;
            eb_q        <= '0;
            hold_q      <= 1'b0;
            ready_q     <= 1'b0;
            ov_q        <= 1'b0;
            ob_q        <= 1'b0;
            od_q        <= 1'b0;
        end else if (ce) begin
            st_q        <= st_d;
            in_cnt_q    <= in_cnt_d;
            chan_cnt_q  <= chan_cnt_d;
            frame_cnt_q <= frame_cnt_d;
            type_q      <= type_d;
            ea_q        <= ea_d;
            eb_q        <= eb_d;
            hold_q      <= hold_d;
            ready_q     <= ready_d;
            ov_q        <= ov_d;
            ob_q        <= ob_d;
            od_q        <= od_d;
        end
    end

    // Outputs straight from flip-flops
    assign s_axi_awready = awready_q;
    assign s_axi_wready  = awready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign in_ready      = ready_q;
    assign out_valid     = ov_q;
    assign out_bit       = ob_q;
    assign out_dtx       = od_q;

    // Checks on the datapath
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_rep_take;
        ce && st_q == rmmd_pkg::ST_RUN && acc && !bypass && !punct && e1 <= 0;
    endsequence
    sequence s_drop_take;
        ce && st_q == rmmd_pkg::ST_RUN && acc && !bypass && punct && !is_x && e1 <= 0;
    endsequence
    chk_rep_copy_next: assert property (s_rep_take |=> st_q == rmmd_pkg::ST_REP && ov_q && ob_q == $past(in_bit)) // RULE8
        else $error("repeat did not hold the bit for a copy");
    chk_rep_stall_in: assert property (st_q == rmmd_pkg::ST_REP |-> !ready_q) // RULE9
        else $error("input ready while emitting copies");
    chk_punct_drop: assert property (s_drop_take |=> !ov_q) // RULE7
        else $error("punctured bit reached the output");
    chk_x_kept: assert property (ce && acc && is_x |=> ov_q && !od_q && ob_q == $past(in_bit)) // RULE1
        else $error("systematic bit not passed");
    chk_bypass_pass: assert property (ce && st_q == rmmd_pkg::ST_RUN && acc && bypass |=> ov_q && ob_q == $past(in_bit)) // RULE18
        else $error("bypass bit not passed");
    chk_pad_dtx: assert property (ce && load && st_q inside {rmmd_pkg::ST_PAD, rmmd_pkg::ST_FLUSH} |=> od_q && !ob_q) // RULE19
        else $error("pad symbol not flagged");
    chk_pad_bound: assert property (load && st_q == rmmd_pkg::ST_PAD |-> chan_cnt_q < pad) // RULE15
        else $error("channel padded beyond reserve");
    chk_flex_bound: assert property (load && st_q == rmmd_pkg::ST_FLUSH |-> frame_cnt_q < pad) // RULE16
        else $error("frame padded beyond total");
    chk_type_rev: assert property (ce && acc && alt_rev && type_q == rmmd_pkg::BT_X |=> type_q == rmmd_pkg::BT_YP) // RULE2
        else $error("wrong alternation after systematic");
    chk_ul_start: assert property (ce && st_q == rmmd_pkg::ST_IDLE && cmd_q[rmmd_pkg::CMD_GO] && !dl
        && transmission_interval == rmmd_pkg::TTI_40 && fidx == 3'h1 |=> type_q == rmmd_pkg::BT_YP) // RULE3
        else $error("wrong starting type");
    chk_count_end: assert property (ready_q |-> in_cnt_q != nbits && st_q == rmmd_pkg::ST_RUN) // RULE10
        else $error("input taken past the bit count");
endmodule

// ==== test_rmmd_top.sv ====
// Purpose: Self-checking bench for the rate match, multiplex and DTX block
// Assumes: Table rows use fixed positions; the flexible frame end is tested by hand
// Notes:   Far side stalls every other cycle
`timescale 1ns/100ps
module test_rmmd_top;
    typedef struct {logic [31:0] ctrl, n, pad, eini, ep, em, pat, t0;} rmmd_row_s;
    logic        aclk = 0, aresetn = 0, ce = 1, restart = 0, out_ready = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, pattern = 0, nbits = 0, rd;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        in_valid, in_ready, in_bit, out_valid, out_bit, out_dtx;
    logic [1:0]  bresp, rresp, rsp;
    logic [1:0]  got[$], exp[$];  // Symbols as {dtx, bit}
    int          error_cnt = 0, check_count = 0;
    // Bypass, puncture, multi-copy repeat, uplink turbo puncture in both cycle orders; t0 is the start type
    rmmd_row_s rows[5] = '{'{32'h11, 32'h5, 32'h8, 32'h0, 32'h0, 32'h0, 32'h16, 32'h0},
                           '{32'h09, 32'h6, 32'h6, 32'h6, 32'hc, 32'h4, 32'h2d, 32'h0},
                           '{32'h01, 32'h4, 32'hc, 32'h4, 32'h8, 32'hc, 32'h9, 32'h0},
                           '{32'hca, 32'h6, 32'h0, 32'h2, 32'h4, 32'h2, 32'h3b, 32'h2},
                           '{32'haa, 32'h6, 32'h0, 32'h2, 32'h4, 32'h2, 32'h2d, 32'h1}};

    rmmd_top uut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .in_valid(in_valid), .in_ready(in_ready), .in_bit(in_bit),
        .out_valid(out_valid), .out_ready(out_ready), .out_bit(out_bit), .out_dtx(out_dtx));
    rmmd_src src (.aclk(aclk), .aresetn(aresetn), .restart(restart), .pattern(pattern),
        .nbits(nbits[7:0]), .in_valid(in_valid), .in_ready(in_ready), .in_bit(in_bit));

    initial begin
        forever #12.5 aclk = ~aclk;
    end

    // Stalling sink collects every accepted symbol
    always @(posedge aclk) begin
        out_ready <= ~out_ready;
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            got.push_back({out_dtx, out_bit});
        end
    end

    task results;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task chk(input string name, input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, want, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin @(posedge aclk); n++; end while ((awready & wready) !== 1'b1 && n < 200);
        awvalid <= 0; wvalid <= 0;
        while (bvalid !== 1'b1 && n < 200) begin @(posedge aclk); n++; end
        r = bresp; bready <= 0;
        if (n >= 200) begin error_cnt++; results; end
    endtask

    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 200);
        arvalid <= 0;
        while (rvalid !== 1'b1 && n < 200) begin @(posedge aclk); n++; end
        d = rdata; r = rresp; rready <= 0;
        if (n >= 200) begin error_cnt++; results; end
    endtask

    task automatic wi(input logic [3:0] i, input logic [31:0] d);
        logic [1:0] r;
        wr({2'b0, i, 2'b0}, d, r);
    endtask

    // One channel job: model, configure, run, compare
    task automatic run_row(input rmmd_row_s w);
        logic [31:0] e [2];  // Accumulators for the two parity streams
        int          n, t, b;
        got.delete(); exp.delete(); e = '{w.eini, w.eini}; t = w.t0;
        for (int k = 0; k < w.n; k++) begin
            b = (w.ctrl[1] && w.ctrl[3] && t == 2);
            if (w.ctrl[4] || (w.ctrl[1] && w.ctrl[3] && t == 0)) begin
                exp.push_back({1'b0, w.pat[k]});
            end else if (w.ctrl[3]) begin
                e[b] = e[b] - w.em;
                if ($signed(e[b]) <= 0) e[b] = e[b] + w.ep;
                else exp.push_back({1'b0, w.pat[k]});
            end else begin
                e[0] = e[0] - w.em;
                exp.push_back({1'b0, w.pat[k]});
                while ($signed(e[0]) <= 0) begin exp.push_back({1'b0, w.pat[k]}); e[0] = e[0] + w.ep; end
            end
            // Uplink 20 and 80 ms step backwards through the type cycle
            t = (t + ((!w.ctrl[0] && w.ctrl[5]) ? 2 : 1)) % 3;
        end
        while (exp.size() < w.pad) exp.push_back(2'h2);
        pattern <= w.pat; nbits <= w.n; restart <= 1;
        @(posedge aclk) restart <= 0;
        wi(rmmd_pkg::REG_CTRL, w.ctrl); wi(rmmd_pkg::REG_NBITS, w.n); wi(rmmd_pkg::REG_PAD, w.pad);
        wi(rmmd_pkg::REG_EINI_A, w.eini); wi(rmmd_pkg::REG_EPLUS_A, w.ep); wi(rmmd_pkg::REG_EMINUS_A, w.em);
        wi(rmmd_pkg::REG_EINI_B, w.eini); wi(rmmd_pkg::REG_EPLUS_B, w.ep); wi(rmmd_pkg::REG_EMINUS_B, w.em);
        wi(rmmd_pkg::REG_CMD, 32'h1);
        n = 0;
        while (got.size() < exp.size() && n < 2000) begin @(posedge aclk); n++; end
        if (n >= 2000) begin error_cnt++; results; end
        repeat (8) @(posedge aclk);
        chk("count", got.size(), exp.size());
        for (int k = 0; k < exp.size(); k++) chk("symbol", got[k], exp[k]);
        rdr(8'h2c, rd, rsp); chk("chan count", rd, exp.size());
        $display("test ctrl %h done", w.ctrl);
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        foreach (rows[r]) run_row(rows[r]);
        // Unmapped place answers with an error and zero data
        rdr(8'h34, rd, rsp); chk("unmapped resp", rsp, rmmd_pkg::RESP_SLVERR);
        chk("unmapped data", rd, 32'h0);
        wr(8'h28, 32'hff, rsp); chk("ro resp", rsp, rmmd_pkg::RESP_OKAY);
        rdr(8'h28, rd, rsp); chk("idle status", rd[0], 1'b0);
        $display("test bus errors done");
        // Flexible positions: clear the frame count, then pad the frame end to the total
        got.delete();
        wi(rmmd_pkg::REG_CTRL, 32'h5); wi(rmmd_pkg::REG_PAD, 32'h3);
        wi(rmmd_pkg::REG_CMD, 32'h4); wi(rmmd_pkg::REG_CMD, 32'h2);
        repeat (20) @(posedge aclk);
        chk("flush count", got.size(), 32'h3);
        foreach (got[k]) chk("flush symbol", got[k], 32'h2);
        rdr(8'h30, rd, rsp); chk("frame count", rd, 32'h3);
        $display("test flexible flush done");
        // Second reset clears configuration
        @(posedge aclk) aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rdr(8'h00, rd, rsp); chk("ctrl reset", rd, rmmd_pkg::CFG_RST);
        rdr(8'h08, rd, rsp); chk("nbits reset", rd, rmmd_pkg::CFG_RST);
        $display("test reset done");
        results;
    end
endmodule
